/* verilog/pcgsa_top.sv */
// peripheral clock gates and i/o short address location registers
// assumes apb master on clk; clk is the master clock from the synthesizer
`timescale 1ns/1ns
`default_nettype none
`include "pcgsa_defs.svh"
module pcgsa_top import pcgsa_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic clock_disable_control,
   input wire logic debug_enable_control,
   input wire logic external_mode_bit,
   input wire logic short_access,
   input wire logic [5:0] short_offset,
   output logic [23:0] short_addr_location,
   output logic debug_port_blocked,
   output logic sys_clk,
   output logic periph_clk,
   output logic [15:0] gated_clks,
   output logic [15:0] gates_active
);
   // ****************************************************
   // register bus decode
   // ****************************************************
   pcgsa_word_t peripheral_clock_gates;
   pcgsa_word_t peripheral_clock_gates_two;
   pcgsa_word_t short_addr_high;
   pcgsa_word_t short_addr_low;
   logic [7:0] idx;
   logic wr_en;
   logic hit;
   assign idx = paddr[9:2];
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   assign hit = (idx == `PCGSA_GATES_IDX) || (idx == `PCGSA_SA_HIGH_IDX) ||
      (idx == `PCGSA_SA_LOW_IDX) || (idx == `PCGSA_GATES_TWO_IDX);
   assign pslverr = psel & penable & ~hit;

   // ****************************************************
   // gate registers
   // ****************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         peripheral_clock_gates <= `PCGSA_GATES_RST;
      end else if (wr_en && idx == `PCGSA_GATES_IDX) begin
         peripheral_clock_gates <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         peripheral_clock_gates_two <= `PCGSA_GATES_TWO_RST;
      end else if (wr_en && idx == `PCGSA_GATES_TWO_IDX) begin
         peripheral_clock_gates_two <= {15'h0000, pwdata[0]};
      end
   end

   gates_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_en && idx == `PCGSA_GATES_IDX) |=>
      peripheral_clock_gates == $past(pwdata[15:0]))
      else $error("gate register write lost");
   gates_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(wr_en && idx == `PCGSA_GATES_IDX) |=>
      $stable(peripheral_clock_gates))
      else $error("gate register moved without a write");
   two_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_en && idx == `PCGSA_GATES_TWO_IDX) |=>
      peripheral_clock_gates_two[0] == $past(pwdata[0]))
      else $error("second can gate write lost");

   // ****************************************************
   // per peripheral gate fields
   // ****************************************************
   // bit 15 of the first register belongs to another block and is unused
   logic converter_b_gate;
   logic converter_a_gate;
   logic can_gate;
   logic decoder_one_gate;
   logic decoder_zero_gate;
   logic timer_d_gate;
   logic timer_c_gate;
   logic timer_b_gate;
   logic timer_a_gate;
   logic serial_comm_one_gate;
   logic serial_comm_zero_gate;
   logic serial_port_one_gate;
   logic serial_port_zero_gate;
   logic modulator_b_gate;
   logic modulator_a_gate;
   logic second_can_gate;
   assign converter_b_gate = peripheral_clock_gates[14];
   assign converter_a_gate = peripheral_clock_gates[13];
   assign can_gate = peripheral_clock_gates[12];
   assign decoder_one_gate = peripheral_clock_gates[11];
   assign decoder_zero_gate = peripheral_clock_gates[10];
   assign timer_d_gate = peripheral_clock_gates[9];
   assign timer_c_gate = peripheral_clock_gates[8];
   assign timer_b_gate = peripheral_clock_gates[7];
   assign timer_a_gate = peripheral_clock_gates[6];
   assign serial_comm_one_gate = peripheral_clock_gates[5];
   assign serial_comm_zero_gate = peripheral_clock_gates[4];
   assign serial_port_one_gate = peripheral_clock_gates[3];
   assign serial_port_zero_gate = peripheral_clock_gates[2];
   assign modulator_b_gate = peripheral_clock_gates[1];
   assign modulator_a_gate = peripheral_clock_gates[0];
   assign second_can_gate = peripheral_clock_gates_two[0];

   // ****************************************************
   // short address location pair
   // ****************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         short_addr_high <= `PCGSA_SA_HIGH_RST;
      end else if (wr_en && idx == `PCGSA_SA_HIGH_IDX) begin
         short_addr_high <= `PCGSA_SA_HIGH_FILL | {14'h0000, pwdata[1:0]};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         short_addr_low <= `PCGSA_SA_LOW_RST;
      end else if (wr_en && idx == `PCGSA_SA_LOW_IDX) begin
         short_addr_low <= pwdata[15:0];
      end
   end

   // value in use trails the registers by three cycles
   logic [17:0] sa_pipe [0:2];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sa_pipe[0] <= `PCGSA_PAIR_RST;
         sa_pipe[1] <= `PCGSA_PAIR_RST;
         sa_pipe[2] <= `PCGSA_PAIR_RST;
      end else begin
         sa_pipe[0] <= {short_addr_high[1:0], short_addr_low};
         sa_pipe[1] <= sa_pipe[0];
         sa_pipe[2] <= sa_pipe[1];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         short_addr_location <= `PCGSA_LOC_RST;
      end else if (short_access) begin
         short_addr_location <= {sa_pipe[1], short_offset};
      end
   end

   assign debug_port_blocked = external_mode_bit &
      ({short_addr_high[1:0], short_addr_low} != `PCGSA_PAIR_RST);

   // the pair is seen as one 18-bit value by the short access path
   high_fill_a: assert property (@(posedge clk) disable iff (!rstn)
      short_addr_high[15:2] == `PCGSA_HIGH_ONES)
      else $error("high register fill bits lost");
   high_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_en && idx == `PCGSA_SA_HIGH_IDX) |=>
      short_addr_high[1:0] == $past(pwdata[1:0]))
      else $error("high register write lost");
   low_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_en && idx == `PCGSA_SA_LOW_IDX) |=>
      short_addr_low == $past(pwdata[15:0]))
      else $error("low register write lost");
   low_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(wr_en && idx == `PCGSA_SA_LOW_IDX) |=>
      $stable(short_addr_low))
      else $error("low register moved without a write");
   high_sel_a: assert property (@(posedge clk) disable iff (!rstn)
      short_access |=>
      short_addr_location[23:22] == $past(short_addr_high[1:0], 3))
      else $error("upper address bits wrong");
   low_sel_a: assert property (@(posedge clk) disable iff (!rstn)
      short_access |=> short_addr_location[21:6] == $past(short_addr_low, 3))
      else $error("middle address bits wrong");
   loc_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !short_access |=> $stable(short_addr_location))
      else $error("short address moved without access");
   dbg_top_a: assert property (@(posedge clk) disable iff (!rstn)
      ({short_addr_high[1:0], short_addr_low} == `PCGSA_PAIR_RST) |->
      !debug_port_blocked)
      else $error("debug blocked at top of memory");
   dbg_ext_a: assert property (@(posedge clk) disable iff (!rstn)
      !external_mode_bit |-> !debug_port_blocked)
      else $error("debug blocked outside external mode");

   // ****************************************************
   // read mux
   // ****************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (idx)
            `PCGSA_GATES_IDX: prdata <= {16'h0000, peripheral_clock_gates};
            `PCGSA_GATES_TWO_IDX:
               prdata <= {16'h0000, peripheral_clock_gates_two};
            `PCGSA_SA_HIGH_IDX: prdata <= {16'h0000, short_addr_high};
            `PCGSA_SA_LOW_IDX: prdata <= {16'h0000, short_addr_low};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   rd_high_a: assert property (@(posedge clk) disable iff (!rstn)
      (psel && !penable && !pwrite && idx == `PCGSA_SA_HIGH_IDX) |=>
      prdata[15:2] == `PCGSA_HIGH_ONES)
      else $error("high register read lost fill bits");
   rd_two_a: assert property (@(posedge clk) disable iff (!rstn)
      (psel && !penable && !pwrite && idx == `PCGSA_GATES_TWO_IDX) |=>
      prdata[15:1] == 15'h0000)
      else $error("reserved bits read nonzero");
   rd_gates_a: assert property (@(posedge clk) disable iff (!rstn)
      (psel && !penable && !pwrite && idx == `PCGSA_GATES_IDX) |=>
      prdata[15:0] == $past(peripheral_clock_gates))
      else $error("gate register read wrong");
   rd_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      !(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
   ready_a: assert property (@(posedge clk) disable iff (!rstn)
      (psel && penable) |-> pready)
      else $error("access phase not ready");
   bad_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_en && !hit) |=> $stable(peripheral_clock_gates) &&
      $stable(short_addr_low))
      else $error("unmapped write landed");

   // ****************************************************
   // clock divide and gating
   // ****************************************************
   logic clk_div;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_div <= 1'b0;
      end else begin
         clk_div <= ~clk_div;
      end
   end

   logic sys_run;
   logic per_run;
   assign sys_run = ~stop_mode & ~wait_mode & ~clock_disable_control;
   assign per_run = ~stop_mode & ~clock_disable_control;
   assign sys_clk = clk_div & sys_run;
   assign periph_clk = clk_div & per_run;

   // wait stops only the system clock; stop and the disable stop both
   sys_run_a: assert property (@(posedge clk) disable iff (!rstn)
      (!stop_mode && !wait_mode && !clock_disable_control) |->
      sys_clk == clk_div)
      else $error("system clock not at half rate");
   per_run_a: assert property (@(posedge clk) disable iff (!rstn)
      (!stop_mode && !clock_disable_control) |-> periph_clk == clk_div)
      else $error("peripheral clock not at half rate");
   sys_wait_a: assert property (@(posedge clk) disable iff (!rstn)
      (wait_mode || stop_mode) |-> !sys_clk)
      else $error("system clock runs in a power mode");
   per_stop_a: assert property (@(posedge clk) disable iff (!rstn)
      (stop_mode || clock_disable_control) |-> !periph_clk)
      else $error("peripheral clock runs while stopped");

   // bit 15 belongs to another block; slot 15 carries the second can
   logic [15:0] gate_req;
   assign gate_req = {second_can_gate, converter_b_gate, converter_a_gate,
      can_gate, decoder_one_gate, decoder_zero_gate, timer_d_gate,
      timer_c_gate, timer_b_gate, timer_a_gate, serial_comm_one_gate,
      serial_comm_zero_gate, serial_port_one_gate, serial_port_zero_gate,
      modulator_b_gate, modulator_a_gate};

   genvar g;
   generate
      for (g = 0; g < `PCGSA_NUM_GATES; g++) begin : gen_gate
         pcgsa_gate u_gate (
            .clk(clk),
            .rstn(rstn),
            .clk_div(clk_div),
            .enable(gate_req[g] & per_run),
            .gated_clk(gated_clks[g]),
            .gate_on(gates_active[g])
         );
      end
   endgenerate

   // ****************************************************
   // checks
   // ****************************************************
   gate_follows_a: assert property (@(posedge clk) disable iff (!rstn)
      (clk_div && per_run && gate_req[0]) |=> gates_active[0])
      else $error("gate did not open");
   gate_stable_a: assert property (@(posedge clk) disable iff (!rstn)
      !clk_div |=> $stable(gates_active))
      else $error("gate moved outside the low phase");
   div_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
      clk_div |=> !clk_div ##1 clk_div)
      else $error("divider not halving");
   two_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      peripheral_clock_gates_two[15:1] == 15'h0000)
      else $error("reserved bits set");
   sa_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      short_access ##1 1'b1 |-> short_addr_location[23:6] ==
      $past({short_addr_high[1:0], short_addr_low}, 3))
      else $error("short address delay wrong");
   sa_offset_a: assert property (@(posedge clk) disable iff (!rstn)
      short_access |=> short_addr_location[5:0] == $past(short_offset))
      else $error("short offset wrong");
   dbg_block_a: assert property (@(posedge clk) disable iff (!rstn)
      (external_mode_bit && short_addr_low != 16'hffff)
      |-> debug_port_blocked)
      else $error("debug not blocked");
   stop_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      stop_mode [*3] |-> gates_active == 16'h0000)
      else $error("gate open in stop");
   gates_next_a: assert property (@(posedge clk) disable iff (!rstn)
      clk_div |=> gates_active ==
      $past({peripheral_clock_gates_two[0], peripheral_clock_gates[14:0]} &
      {16{per_run}}))
      else $error("gate state does not follow its bits");
   gated_low_a: assert property (@(posedge clk) disable iff (!rstn)
      !clk_div |-> gated_clks == 16'h0000)
      else $error("gated clock high in the low phase");
   gated_high_a: assert property (@(posedge clk) disable iff (!rstn)
      clk_div |-> gated_clks == gates_active)
      else $error("gated clock does not match its gate");

   // ****************************************************
   // gate cell checks
   // ****************************************************
   generate
      for (g = 0; g < `PCGSA_NUM_GATES; g++) begin : gen_gate_chk
         gate_off_a: assert property (@(posedge clk) disable iff (!rstn)
            (clk_div && !gate_req[g]) |=> !gates_active[g])
            else $error("gate did not close");
         gate_on_a: assert property (@(posedge clk) disable iff (!rstn)
            (clk_div && gate_req[g] && per_run) |=> gates_active[g])
            else $error("gate did not open");
      end
   endgenerate
endmodule // pcgsa_top
`default_nettype wire

/* verilog/pcgsa_defs.svh */
// constants for the peripheral clock gate and short address block
// assumes an apb slave with 32-bit data, registers one per aligned word
`ifndef PCGSA_DEFS_SVH
`define PCGSA_DEFS_SVH
`define PCGSA_GATES_IDX 8'h0c
`define PCGSA_SA_HIGH_IDX 8'h0d
`define PCGSA_SA_LOW_IDX 8'h0e
`define PCGSA_GATES_TWO_IDX 8'h0f
`define PCGSA_GATES_RST 16'hffff
`define PCGSA_GATES_MASK 16'h7fff
`define PCGSA_GATES_TWO_RST 16'h0001
`define PCGSA_SA_HIGH_RST 16'hffff
`define PCGSA_SA_LOW_RST 16'hffff
`define PCGSA_SA_HIGH_FILL 16'hfffc
`define PCGSA_SA_DELAY 3
`define PCGSA_NUM_GATES 16
`define PCGSA_PAIR_RST 18'h3ffff
`define PCGSA_LOC_RST 24'hffffff
`define PCGSA_HIGH_ONES 14'h3fff
`endif

/* verilog/pcgsa_pkg.sv */
// types for the peripheral clock gate and short address block
// assumes nothing of its surroundings
package pcgsa_pkg;
   typedef logic [15:0] pcgsa_word_t;
   typedef logic [23:0] pcgsa_addr_t;
endpackage

/* verilog/pcgsa_gate.sv */
// glitch-free clock gate cell for one peripheral
// assumes clk_div is a flop output of clk, the master clock
`timescale 1ns/1ns
`default_nettype none
module pcgsa_gate (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_div,
   input wire logic enable,
   output logic gated_clk,
   output logic gate_on
);
   // enable is taken at the end of a high phase, so the new state shows
   // from the falling edge of the divided clock and holds through the
   // next high phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gate_on <= 1'b0;
      end else if (clk_div) begin
         gate_on <= enable;
      end
   end

   // the gated clock comes from a flop, so no runt reaches the peripheral
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gated_clk <= 1'b0;
      end else begin
         gated_clk <= ~clk_div & gate_on;
      end
   end
endmodule // pcgsa_gate
`default_nettype wire

/* verification/pcgsa_periph_model.sv */
// peripheral side model: counts the edges of every clock it receives
// assumes clr is pulsed by the bench between count windows
`timescale 1ns/1ns
`default_nettype none
module pcgsa_periph_model (
   input wire logic clr,
   input wire logic sys_clk,
   input wire logic periph_clk,
   input wire logic [15:0] gated_clks,
   output var int cnt [16],
   output var int pcnt,
   output var int scnt
);
   always @(posedge sys_clk or posedge clr) begin
      scnt <= clr ? 0 : scnt + 1;
   end
   // ****
   // edge counters
   // ****
   always @(posedge periph_clk or posedge clr) begin
      pcnt <= clr ? 0 : pcnt + 1;
   end
   for (genvar i = 0; i < 16; i++) begin : g_cnt
      always @(posedge gated_clks[i] or posedge clr) begin
         cnt[i] <= clr ? 0 : cnt[i] + 1;
      end
   end
endmodule // pcgsa_periph_model
`default_nettype wire

/* verification/testbench.sv */
// bench for pcgsa_top: register rows, short address, clock gates
// assumes pcgsa_periph_model counts the gated clock edges
`timescale 1ns/1ns
`default_nettype none
`include "pcgsa_defs.svh"
`define CHK(n, e, s) begin \
   n_compared++; \
   if ((e) !== (s)) begin \
      error_cnt++; \
      $display("MISMATCH %s exp %h got %h", n, e, s); \
   end \
end
module testbench;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic short_access = 0, stop_mode = 0, wait_mode = 0, ext = 0, clr = 0;
   logic cdis = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [5:0] short_offset = 0;
   logic pready, pslverr, dpb, sys_clk, periph_clk, e;
   logic [23:0] sal;
   logic [15:0] gated_clks, gates_active;
   int cnt [16];
   int pcnt, scnt, cyc = 0, error_cnt = 0, n_compared = 0;
   logic [11:0] ra [4] = '{{`PCGSA_GATES_IDX, 2'b00},
      {`PCGSA_GATES_TWO_IDX, 2'b00}, {`PCGSA_SA_HIGH_IDX, 2'b00},
      {`PCGSA_SA_LOW_IDX, 2'b00}};
   logic [15:0] rr [4] = '{16'hffff, 16'h0001, 16'hffff, 16'hffff};
   logic [15:0] rw [4] = '{16'h1234, 16'hffff, 16'h0000, 16'habcd};
   logic [15:0] re [4] = '{16'h1234, 16'h0001, 16'hfffc, 16'habcd};
   pcgsa_top uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
      .wait_mode(wait_mode), .clock_disable_control(cdis),
      .debug_enable_control(1'b0), .external_mode_bit(ext),
      .short_access(short_access), .short_offset(short_offset),
      .short_addr_location(sal), .debug_port_blocked(dpb),
      .sys_clk(sys_clk), .periph_clk(periph_clk),
      .gated_clks(gated_clks), .gates_active(gates_active));
   pcgsa_periph_model pm (.clr(clr), .sys_clk(sys_clk),
      .periph_clk(periph_clk), .gated_clks(gated_clks), .cnt(cnt),
      .pcnt(pcnt), .scnt(scnt));
   // ****
   // clock, timeout and tasks
   // ****
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         finish_test();
      end
   end
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task sa(input logic [5:0] o, input logic [23:0] x);
      short_access <= 1;
      short_offset <= o;
      @(posedge clk);
      short_access <= 0;
      @(posedge clk);
      `CHK("short_addr", x, sal)
   endtask
   // count edges over 20 cycles once the gates have settled
   task win;
      repeat (4) @(negedge clk);
      clr = 1;
      @(negedge clk);
      clr = 0;
      repeat (20) @(negedge clk);
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1;
      `CHK("sal_rst", 24'hffffff, sal)
      for (int i = 0; i < 4; i++) begin
         apb(0, ra[i], 0);
         `CHK("rst_val", rr[i], q[15:0])
         apb(1, ra[i], {16'h0000, rw[i]});
         apb(0, ra[i], 0);
         `CHK("reg_val", re[i], q[15:0])
      end
      apb(0, 12'h100, 0);
      `CHK("unmapped", 1'b1, e)
      $display("test registers done");
      ext <= 1;
      sa(6'h2a, {2'b00, 16'habcd, 6'h2a});
      `CHK("blocked", 1'b1, dpb)
      apb(1, ra[3], 32'h1111);
      sa(6'h01, {2'b00, 16'habcd, 6'h01});
      sa(6'h01, {2'b00, 16'h1111, 6'h01});
      apb(1, ra[2], 32'h3);
      apb(1, ra[3], 32'hffff);
      repeat (4) @(posedge clk);
      `CHK("unblocked", 1'b0, dpb)
      ext <= 0;
      $display("test short address done");
      apb(1, ra[0], 32'h1);
      apb(1, ra[1], 32'h0);
      win();
      `CHK("active", 16'h0001, gates_active)
      `CHK("periph_rate", 10, pcnt)
      `CHK("sys_rate", 10, scnt)
      `CHK("gate_on", 10, cnt[0])
      `CHK("gate_off", 0, cnt[1] + cnt[15])
      @(posedge clk);
      stop_mode <= 1;
      win();
      `CHK("stopped", 0, pcnt + cnt[0])
      @(posedge clk);
      stop_mode <= 0;
      wait_mode <= 1;
      win();
      `CHK("wait_run", 10, pcnt)
      `CHK("wait_sys", 0, scnt)
      @(posedge clk);
      wait_mode <= 0;
      cdis <= 1;
      win();
      `CHK("disabled", 0, pcnt + scnt + cnt[0])
      @(posedge clk);
      cdis <= 0;
      apb(1, ra[0], 32'h0);
      apb(1, ra[1], 32'h1);
      win();
      `CHK("second_can_gate_active", 16'h8000, gates_active)
      `CHK("second_can_gate_on", 10, cnt[15])
      `CHK("gate0_off", 0, cnt[0])
      $display("test gates done");
      @(posedge clk);
      rstn <= 0;
      @(posedge clk);
      rstn <= 1;
      `CHK("rst_gates", 16'h0000, gates_active)
      `CHK("rst_sal", 24'hffffff, sal)
      apb(0, ra[1], 0);
      `CHK("rst_two", 16'h0001, q[15:0])
      apb(0, ra[3], 0);
      `CHK("rst_low", 16'hffff, q[15:0])
      $display("test reset done");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
